// File: verilog/sep_pkg.sv
package sep_pkg;

  // ==========================================================
  // Word and frame geometry
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned ADDR_BITS = 8;
  localparam int unsigned HDR_BITS  = 10;
  localparam int unsigned DATA_BITS = 16;
  localparam int unsigned CMD_BITS  = HDR_BITS + DATA_BITS;
  localparam int unsigned CNT_W     = 5;

  // Frame bit counter landmarks
  localparam logic [4:0] CNT_IDLE  = 5'h00;
  localparam logic [4:0] CNT_LEAD  = 5'h01;
  localparam logic [4:0] CNT_HDR   = 5'h0a;
  localparam logic [4:0] CNT_DLAST = 5'h1a;
  localparam logic [4:0] CNT_OVER  = 5'h1b;

  // ==========================================================
  // Op-codes, and the sub-codes held in the top two address bits
  typedef enum logic [1:0] {
    OP_EXT   = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_ERASE = 2'h3
  } sep_op_e;

  localparam logic [1:0] SUB_LOCK   = 2'h0;
  localparam logic [1:0] SUB_FILL   = 2'h1;
  localparam logic [1:0] SUB_ERALL  = 2'h2;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;

  localparam logic [15:0] ERASED_WORD = 16'hffff;

  typedef struct packed {
    sep_op_e     op;
    logic [7:0]  addr;
    logic [15:0] data;
  } sep_cmd_s;

  // Bundle of link-side levels carried into the mclk domain
  typedef struct packed {
    logic cs;
    logic done;
    logic rd_req;
    logic lead;
    logic dout;
  } sep_xing_s;

  // ==========================================================
  // Timing
  localparam int unsigned MCLK_PERIOD_NS = 50;
  localparam int unsigned PROG_TIME_NS   = 10_000_000;
  // Longest time: rounds down
  localparam int unsigned PROG_CYCLES    = PROG_TIME_NS / MCLK_PERIOD_NS;

endpackage

// File: verilog/sep_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sep_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: verilog/sep_mem.sv
`timescale 1ns/1ps
`default_nettype none

module sep_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 16
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
      cells[waddr] <= wdata;
    rdata_q <= cells[raddr];
  end

endmodule

`default_nettype wire

// File: verilog/sep_port.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Status on serial_out while chip_select high
// - Chip select fall starts self-timed cycle
// - Erase every word sets all ones
// - Fill every word with supplied pattern
// - Program lock disables erase and write
// - Reads work whether locked or unlocked
// - Read: one, op 10, address
// - Erase: one, op 11, address
// - Erase every word: op 00, address 10
// - Write: one, op 01, address, data
// - Fill: op 00, address 01, data
// - Lock: one, op 00, address 00
// - Small variant ignores top address bit
// - Read streams on to next word
// - Read sends zero bit, then word
// - Data bits on serial_out move only after clock rise; ready rises when the cycle ends
// - Power-up leaves programming locked
module sep_port
  import sep_pkg::*;
#(
  parameter int unsigned ADDR_W     = 8,
  parameter int unsigned PROG_COUNT = PROG_CYCLES
) (
  // System clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Serial link
  input  wire logic serial_clock,
  input  wire logic chip_select,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe
);

  // ==========================================================
  // Elaboration checks
  localparam int unsigned DEPTH = 1 << ADDR_W;

  if (ADDR_W < 7 || ADDR_W > ADDR_BITS)
    $error("sep_port: ADDR_W must be 7 or 8");
  if (PROG_COUNT <= DEPTH)
    $error("sep_port: PROG_COUNT must exceed the word count");

  function automatic logic [ADDR_W-1:0] word_addr(input logic [7:0] a);
    word_addr = a[ADDR_W-1:0];
  endfunction

  function automatic logic needs_data(input sep_op_e op, input logic [1:0] sub);
    needs_data = (op == OP_WRITE) || (op == OP_EXT && sub == SUB_FILL);
  endfunction

  // ==========================================================
  // Link domain: frame decode on serial_clock
  // Chip select low ends the frame asynchronously, since the link clock
  // stops between frames and no edge would arrive to clear the counter.
  logic             frame_clr;
  logic [CNT_W-1:0] cnt_q;
  logic [8:0]       hdr_sr_q;
  logic             lead_q;
  logic             rd_mode_q;
  logic [3:0]       rbit_q;
  logic [15:0]      sh_q;

  logic             done_q;
  logic             rd_req_q;
  logic [ADDR_W-1:0] rd_addr_q;
  sep_cmd_s         cmd_q;

  logic [WORD_W-1:0] rdata_hold_q;

  logic [9:0] hdr_w;
  sep_op_e    hdr_op;
  logic [7:0] hdr_addr;
  logic       at_lead;
  logic       at_hdr;
  logic       in_data;
  logic       rd_load;

  assign frame_clr = sys_rst | ~chip_select;
  assign hdr_w     = {hdr_sr_q, serial_in};
  assign hdr_op    = sep_op_e'(hdr_w[9:8]);
  assign hdr_addr  = hdr_w[7:0];
  assign at_lead   = (cnt_q == CNT_IDLE) && serial_in;
  assign at_hdr    = (cnt_q == CNT_HDR) && !rd_mode_q;
  assign in_data   = (cnt_q > CNT_HDR) && (cnt_q <= CNT_DLAST)
                     && needs_data(cmd_q.op, cmd_q.addr[7:6]);
  assign rd_load   = rd_mode_q && (rbit_q == 4'h0);

  always_ff @(posedge serial_clock or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      cnt_q     <= CNT_IDLE;
      hdr_sr_q  <= '0;
      lead_q    <= 1'b0;
      rd_mode_q <= 1'b0;
      rbit_q    <= 4'h0;
      sh_q      <= '0;
    end
    else if (cnt_q == CNT_IDLE)
    begin
      // Leading zeros before the lead one bit are skipped
      if (serial_in)
      begin
        cnt_q  <= CNT_LEAD;
        lead_q <= 1'b1;
      end
    end
    else if (rd_mode_q)
    begin
      // Reload from the prefetched word every sixteenth edge
      sh_q   <= rd_load ? rdata_hold_q : {sh_q[14:0], 1'b0};
      rbit_q <= rbit_q + 4'h1;
    end
    else
    begin
      hdr_sr_q <= hdr_w[8:0];
      if (cnt_q != CNT_OVER)
        cnt_q <= cnt_q + 5'h01;
      if (at_hdr && hdr_op == OP_READ)
      begin
        // Zero bit goes out on this edge, word follows
        rd_mode_q <= 1'b1;
        sh_q      <= '0;
        rbit_q    <= 4'h0;
      end
    end
  end

  always_ff @(posedge serial_clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_q    <= 1'b0;
      rd_req_q  <= 1'b0;
      rd_addr_q <= '0;
      cmd_q     <= '0;
    end
    else if (chip_select)
    begin
      if (at_lead)
        done_q <= 1'b0;
      else if (at_hdr)
      begin
        cmd_q.op   <= hdr_op;
        cmd_q.addr <= hdr_addr;
        if (hdr_op == OP_READ)
        begin
          rd_addr_q <= word_addr(hdr_addr);
          rd_req_q  <= ~rd_req_q;
        end
        else
          // Erase and the op-00 forms other than fill end at the address
          done_q <= !needs_data(hdr_op, hdr_addr[7:6]);
      end
      else if (in_data)
      begin
        cmd_q.data <= {cmd_q.data[14:0], serial_in};
        if (cnt_q == CNT_DLAST)
          done_q <= 1'b1;
      end
      else if (rd_load)
      begin
        // Prefetch the next word while this one shifts out
        rd_addr_q <= rd_addr_q + 1'b1;
        rd_req_q  <= ~rd_req_q;
      end
      else if (!rd_mode_q && cnt_q > CNT_HDR)
        // An edge after the last bit spoils the command
        done_q <= 1'b0;
    end
  end

  // ==========================================================
  // Crossing into mclk
  // Command words and the read address are quasi-static: they settle on a
  // link edge and are only sampled after the matching flag has passed two
  // flip-flops. The read word goes back the same way, relying on the link
  // clock's half period being far longer than the fetch.
  sep_xing_s xing_d;
  sep_xing_s xing_s;

  assign xing_d = '{cs: chip_select, done: done_q, rd_req: rd_req_q,
                    lead: lead_q, dout: sh_q[15]};

  sep_sync #(
    .W ($bits(sep_xing_s))
  ) u_sync (
    .clk (mclk),
    .rst (sys_rst),
    .d   (xing_d),
    .q   (xing_s)
  );

  // ==========================================================
  // Programming engine
  typedef enum logic {
    PG_IDLE,
    PG_RUN
  } sep_pg_e;

  localparam logic [31:0] PROG_LAST = 32'(PROG_COUNT - 1);

  sep_pg_e           pg_q;
  logic [31:0]       timer_q;
  logic              prog_en_q;
  logic              all_q;
  logic              wr_pend_q;
  logic [ADDR_W-1:0] wptr_q;
  logic [WORD_W-1:0] wdata_q;
  logic              cs_prev_q;
  logic              armed_q;
  logic              req_seen_q;
  logic              status_q;
  logic              out_q;
  logic              oe_q;

  logic              cs_fall;
  logic              start;
  logic              is_unlock;
  logic              is_lock;
  logic              is_prog;
  logic              is_all;
  logic [WORD_W-1:0] cmd_word;
  logic              pg_idle;
  logic              rd_hit;
  logic [WORD_W-1:0] mem_rdata;
  logic              mem_we;
  logic              walk_end;

  assign cs_fall   = cs_prev_q && !xing_s.cs;
  // Only a frame that carried a lead bit may start a cycle; a bare status frame must not repeat it
  assign start     = cs_fall && xing_s.done && pg_idle && armed_q;
  assign pg_idle   = (pg_q == PG_IDLE);
  assign is_unlock = (cmd_q.op == OP_EXT) && (cmd_q.addr[7:6] == SUB_UNLOCK);
  assign is_lock   = (cmd_q.op == OP_EXT) && (cmd_q.addr[7:6] == SUB_LOCK);
  assign is_all    = (cmd_q.op == OP_EXT)
                     && (cmd_q.addr[7:6] == SUB_ERALL || cmd_q.addr[7:6] == SUB_FILL);
  assign is_prog   = (cmd_q.op == OP_WRITE) || (cmd_q.op == OP_ERASE) || is_all;
  // Erase writes all ones, write and fill take the shifted data
  assign cmd_word  = (cmd_q.op == OP_ERASE || (is_all && cmd_q.addr[7:6] == SUB_ERALL))
                     ? ERASED_WORD : cmd_q.data;
  assign rd_hit    = xing_s.rd_req ^ req_seen_q;
  assign mem_we    = (pg_q == PG_RUN) && wr_pend_q;
  assign walk_end  = !all_q || (wptr_q == ADDR_W'(DEPTH - 1));

  sep_mem #(
    .AW (ADDR_W),
    .DW (WORD_W)
  ) u_mem (
    .clk     (mclk),
    .we      (mem_we),
    .waddr   (wptr_q),
    .wdata   (wdata_q),
    .raddr   (rd_addr_q),
    .rdata_q (mem_rdata)
  );

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      prog_en_q <= 1'b0;
      pg_q      <= PG_IDLE;
      timer_q   <= '0;
      all_q     <= 1'b0;
      wr_pend_q <= 1'b0;
      wptr_q    <= '0;
      wdata_q   <= '0;
    end
    else
    begin
      unique case (pg_q)
        PG_IDLE:
        begin
          if (start && is_unlock)
            prog_en_q <= 1'b1;
          else if (start && is_lock)
            prog_en_q <= 1'b0;
          else if (start && is_prog && prog_en_q)
          begin
            pg_q      <= PG_RUN;
            timer_q   <= PROG_LAST;
            all_q     <= is_all;
            wr_pend_q <= 1'b1;
            wptr_q    <= is_all ? '0 : word_addr(cmd_q.addr);
            wdata_q   <= cmd_word;
          end
        end
        PG_RUN:
        begin
          // Whole-array forms walk every word, one per mclk
          if (wr_pend_q)
          begin
            wptr_q    <= wptr_q + 1'b1;
            wr_pend_q <= !walk_end;
          end
          timer_q <= timer_q - 32'h1;
          if (timer_q == 32'h0)
            pg_q <= PG_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Read fetch and serial_out
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cs_prev_q    <= 1'b0;
      armed_q      <= 1'b0;
      req_seen_q   <= 1'b0;
      rdata_hold_q <= '0;
      status_q     <= 1'b0;
      out_q        <= 1'b0;
      oe_q         <= 1'b0;
    end
    else
    begin
      cs_prev_q  <= xing_s.cs;
      armed_q    <= xing_s.lead || (armed_q && !cs_fall);
      req_seen_q <= xing_s.rd_req;
      // Reads ignore the lock state
      if (rd_hit)
        rdata_hold_q <= mem_rdata;
      if (start && is_prog && prog_en_q)
        status_q <= 1'b1;
      else if (xing_s.lead && pg_idle)
        status_q <= 1'b0;
      oe_q  <= xing_s.cs;
      // Low while busy, high once ready
      out_q <= status_q ? pg_idle : xing_s.dout;
    end
  end

  assign serial_out    = out_q;
  assign serial_out_oe = oe_q;

endmodule

`default_nettype wire

// File: testbench/sep_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module sep_port_assertions (
  // System clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial link
  input wire logic serial_clock,
  input wire logic chip_select,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic [1:0] sk_q;
  logic [3:0] sk_age_q;
  logic [3:0] cs_age_q;
  wire        cs_steady;

  // Own copy of the link clock sync, so output moves can be tied to a rise
  assign cs_steady = cs_age_q > 4'h7;
  always_ff @(posedge mclk)
  begin
    sk_q     <= sys_rst ? 2'h0 : {sk_q[0], serial_clock};
    sk_age_q <= (sys_rst || sk_q == 2'h1) ? 4'h0 : sk_age_q + {3'h0, sk_age_q != 4'hf};
    cs_age_q <= !chip_select ? 4'h0 : cs_age_q + {3'h0, cs_age_q != 4'hf};
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_RST_QUIET: assert property ($fell(sys_rst) |-> !serial_out && !serial_out_oe)
    else $error("outputs busy after reset");
  AST_OE_RISE: assert property ($rose(chip_select) |-> ##[2:3] serial_out_oe)
    else $error("enable late");
  AST_OE_FALL: assert property ($fell(chip_select) |-> ##[2:3] !serial_out_oe)
    else $error("enable stuck");
  AST_OE_CAUSE: assert property ($rose(serial_out_oe) |-> $past(chip_select, 2))
    else $error("enable without select");
  AST_OE_HOLD: assert property (chip_select [*4] |-> serial_out_oe)
    else $error("enable dropped");
  AST_OE_IDLE: assert property (!chip_select [*4] |-> !serial_out_oe)
    else $error("enable while idle");
  AST_FALL_NEEDS_SK: assert property ($fell(serial_out) && cs_steady |-> sk_age_q < 4'h6)
    else $error("output fell without clock");
  AST_HIGH_STANDS: assert property (serial_out && cs_steady && sk_age_q > 4'h5 |=> serial_out)
    else $error("output one lost");
endmodule

bind sep_port sep_port_assertions i_chk (
  .mclk         (mclk),
  .sys_rst      (sys_rst),
  .serial_clock (serial_clock),
  .chip_select  (chip_select),
  .serial_out   (serial_out),
  .serial_out_oe(serial_out_oe)
);
`default_nettype wire

// File: testbench/sep_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Controller model: link clock idle between frames, 600 ns per bit
module sep_host #(
  parameter int H = 25
) (
  // Base clock
  input  wire logic link_clk,
  // Link
  input  wire logic serial_out,
  output logic      serial_clock,
  output logic      chip_select,
  output logic      serial_in
);
  initial
  begin
    serial_clock = 1'b0;
    chip_select  = 1'b0;
    serial_in    = 1'b0;
  end

  // Output is taken at the fall, well after the device settles
  task automatic bit1(input logic b, output logic o);
    serial_in = b;
    repeat (H) @(posedge link_clk);
    serial_clock = 1'b1;
    repeat (H) @(posedge link_clk);
    serial_clock = 1'b0;
    o = serial_out;
  endtask

  task automatic hdr(input logic [10:0] h, output logic o);
    chip_select = 1'b1;
    for (int i = 10; i >= 0; i--)
      bit1(h[i], o);
  endtask

  task automatic word(input logic [15:0] d, output logic [15:0] q);
    for (int i = 15; i >= 0; i--)
      bit1(d[i], q[i]);
  endtask

  // Released data line shows the inverse so a stale level is not trusted
  task automatic stop();
    chip_select = 1'b0;
    serial_in   = ~serial_in;
    repeat (2 * H) @(posedge link_clk);
  endtask

  task automatic sel();
    chip_select = 1'b1;
    repeat (H) @(posedge link_clk);
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_serial_eeprom_command_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_command_port import sep_pkg::*;;
  logic        mclk = 1'b0;
  logic        link_clk = 1'b0;
  logic        sys_rst;
  logic        serial_clock;
  logic        chip_select;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  logic        o;
  logic        unl;
  logic [15:0] q;
  logic [7:0]  a;
  logic [15:0] mem [256];
  int          seed;
  int          mismatches;
  int          tests_run;

  always #25 mclk = ~mclk;
  initial
  begin
    #3.1;
    forever #6 link_clk = ~link_clk;
  end

  sep_port #(.ADDR_W(8), .PROG_COUNT(300)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .serial_clock(serial_clock),
    .chip_select(chip_select), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  sep_host i_host (.link_clk(link_clk), .serial_out(serial_out), .serial_clock(serial_clock),
    .chip_select(chip_select), .serial_in(serial_in));

  // ==========
  // Helpers
  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic status(input logic ok);
    int n;
    i_host.stop();
    i_host.sel();
    check("busy", {15'h0, serial_out}, 16'h0);
    for (n = 0; n < 400 && serial_out !== 1'b1; n++)
      @(negedge mclk);
    check("ready", {15'h0, serial_out}, {15'h0, ok});
    if (ok && n == 400)
      wrap_up();
    i_host.stop();
  endtask

  task automatic key(input logic [1:0] sub);
    i_host.hdr({1'b1, OP_EXT, sub, 6'(rnd())}, o);
    i_host.stop();
    unl = sub == SUB_UNLOCK;
  endtask

  // A cut command gets one more clock after its last bit
  task automatic prog(input sep_op_e op, input logic [7:0] ad, input logic [15:0] d, input logic cut);
    logic fill;
    logic ok;
    fill = op == OP_EXT && ad[7:6] == SUB_FILL;
    ok   = unl && !cut;
    i_host.hdr({1'b1, op, ad}, o);
    if (op == OP_WRITE || fill)
      i_host.word(d, q);
    if (cut)
      i_host.bit1(1'b0, o);
    for (int i = 0; i < 256; i++)
      if (ok && (op == OP_EXT || i == ad))
        mem[i] = (op == OP_WRITE || fill) ? d : ERASED_WORD;
    status(ok);
  endtask

  task automatic rd(input logic [7:0] ad, input int n);
    i_host.hdr({1'b1, OP_READ, ad}, o);
    check("dummy", {15'h0, o}, 16'h0);
    repeat (n)
    begin
      i_host.word(rnd(), q);
      check("data", q, mem[ad]);
      ad++;
    end
    i_host.stop();
  endtask

  // ==========
  // Main sequence
  initial
  begin
    seed       = 76868;
    mismatches = 0;
    tests_run  = 0;
    unl        = 1'b0;
    sys_rst    = 1'b1;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    key(SUB_UNLOCK);
    prog(OP_EXT, {SUB_FILL, 6'(rnd())}, rnd(), 1'b0);
    rd(8'hfe, 3);
    repeat (3)
    begin
      a = 8'(rnd());
      prog(OP_WRITE, a, rnd(), 1'b0);
      rd(a, 1);
    end
    prog(OP_WRITE, a, rnd(), 1'b1);
    prog(OP_ERASE, a + 8'h1, 16'h0, 1'b0);
    rd(a, 2);
    key(SUB_LOCK);
    prog(OP_WRITE, a, rnd(), 1'b0);
    prog(OP_ERASE, a, 16'h0, 1'b0);
    prog(OP_EXT, {SUB_ERALL, 6'(rnd())}, 16'h0, 1'b0);
    rd(a, 2);
    key(SUB_UNLOCK);
    prog(OP_EXT, {SUB_ERALL, 6'(rnd())}, 16'h0, 1'b0);
    rd(8'(rnd()), 2);
    sys_rst = 1'b1;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    unl     = 1'b0;
    repeat (4) @(negedge mclk);
    prog(OP_WRITE, a, rnd(), 1'b0);
    rd(a, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
